//--- dv/manual_door_cam_interlock_bench.sv
`timescale 1ns/1ns
module manual_door_cam_interlock_bench;
   import mdc_pkg::*;
   localparam int CAM = 0, PRM = 1, FLT = 2, EST = 3, RES = 4, LIT = 5, IRQ = 6;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        hall_primary_lock_in, series_lock_in, curtain_clear_in;
   logic        leveling_zone_in, unlock_zone_in, run_dir_req, car_running;
   logic        cam_relay_out, car_top_close_out, alt_cam_out_a, alt_cam_out_b;
   logic        brake_release_ok, run_permit, emergency_stop, rescue_run, cancel_calls;
   logic        lock_close_timeout_fault, curtain_run_fault, cabin_light_on, irq;
   logic        door_req, jam_aux, shade, level_req, zone_req;
   logic [7:0]  aux_dly, obs, hold;
   logic [32:0] exq[$], mkq[$];
   int          failures = 0, tests_run = 0, cancel_cnt = 0, n;

   mdc_interlock #(.TICK_CYC(4)) mdc_interlock_i (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .hall_primary_lock_in, .series_lock_in, .curtain_clear_in, .leveling_zone_in,
      .unlock_zone_in, .run_dir_req, .car_running, .cam_relay_out, .car_top_close_out,
      .alt_cam_out_a, .alt_cam_out_b, .brake_release_ok, .run_permit, .emergency_stop,
      .rescue_run, .cancel_calls, .lock_close_timeout_fault, .curtain_run_fault,
      .cabin_light_on, .irq);
   mdc_door_model mdc_door_model_i (
      .clk, .rst, .cam_relay_out, .door_req, .jam_aux, .shade, .level_req, .zone_req,
      .aux_dly, .hall_primary_lock_in, .series_lock_in, .curtain_clear_in,
      .leveling_zone_in, .unlock_zone_in);

   ////////////////////////////////////////////////////////////////////////////////////
   // clock, watched outputs and call-cancel pulse count
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   assign obs = {1'b0, irq, cabin_light_on, rescue_run, emergency_stop,
                 lock_close_timeout_fault, run_permit, cam_relay_out};
   always @(posedge clk) if (cancel_calls === 1'b1) cancel_cnt++;

   // read monitor: compares each completed read with the oldest note
   always @(posedge clk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         tests_run++;
         if (exq.size() == 0) begin
            $display("MISMATCH %0t unexpected read", $time);
            failures++;
         end else if ((({pslverr, prdata} ^ exq[0]) & mkq[0]) !== 33'h0) begin
            $display("MISMATCH %0t read %h exp %h", $time, {pslverr, prdata}, exq[0]);
            failures++;
         end
         if (exq.size() != 0) begin
            void'(exq.pop_front());
            void'(mkq.pop_front());
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         failures++;
      end
   endtask : chk

   // bounded wait for one watched output to reach a level; n counts cycles
   task automatic wait_bit(input int i, input logic v, input int lim, output int k);
      k = 0;
      while (obs[i] !== v) begin
         @(posedge clk);
         k++;
         if (k > lim) begin
            $display("MISMATCH %0t wait on output %0d", $time, i);
            failures++;
            stop_test();
         end
      end
   endtask : wait_bit

   // one apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         $display("MISMATCH %0t bus hang", $time);
         failures++;
         stop_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
      exq.push_back(e);
      mkq.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {run_dir_req, car_running, door_req, jam_aux, shade, zone_req} = '0;
      level_req = 1'b1;
      rst = 1'b1;
      void'($urandom(32'hE4D64EB0));
      aux_dly = 8'($urandom_range(60, 20));
      hold = 8'($urandom_range(9, 0));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      rd(ADDR_CTRL, 33'h0, '1);
      rd(ADDR_CFG, 33'h0A, '1);
      rd(12'h020, 33'h100000000, '1);
      apb(1'b1, ADDR_CFG, {8'h00, SEL_CAM_INV, SEL_CAM, hold});
      // door open, then bad config, then shaded curtain: no cam
      run_dir_req <= 1'b1;
      repeat (20) @(posedge clk);
      chk({cam_relay_out, alt_cam_out_b}, 2'b01);
      door_req <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h0F);
      repeat (20) @(posedge clk);
      chk(cam_relay_out, 1'b0);
      shade <= 1'b1;
      repeat (5) @(posedge clk);                                  // shaded curtain filtered first
      apb(1'b1, ADDR_CTRL, 32'h07);
      repeat (20) @(posedge clk);
      chk({cam_relay_out, car_top_close_out}, 2'b00);
      shade <= 1'b0;
      wait_bit(CAM, 1'b1, 20, n);
      chk({car_top_close_out, alt_cam_out_a, alt_cam_out_b, run_permit}, 4'hC);
      wait_bit(PRM, 1'b1, 90, n);
      chk({brake_release_ok, series_lock_in}, 2'b11);
      // curtain shaded while running, then rescue to leveling and hold time
      level_req <= 1'b0;
      car_running <= 1'b1;
      repeat (10) @(posedge clk);
      shade <= 1'b1;
      wait_bit(EST, 1'b1, 20, n);
      chk({curtain_run_fault, run_permit}, 2'b10);
      shade <= 1'b0;
      wait_bit(RES, 1'b1, 20, n);
      run_dir_req <= 1'b0;
      level_req <= 1'b1;
      wait_bit(RES, 1'b0, 20, n);
      car_running <= 1'b0;
      chk(curtain_run_fault, 1'b0);
      wait_bit(CAM, 1'b0, 500, n);
      chk(n >= 380, 1'b1);
      // jammed lock: three timeouts, retries, then a latched fault
      jam_aux <= 1'b1;
      run_dir_req <= 1'b1;
      for (int t = 0; t < 3; t++) begin
         wait_bit(CAM, 1'b1, 300, n);
         wait_bit(FLT, 1'b1, 450, n);
         chk(n >= 385, 1'b1);
         chk(cam_relay_out, 1'b0);
         if (t < 2) begin
            wait_bit(FLT, 1'b0, 260, n);
            chk(n >= 190, 1'b1);
            chk(32'(cancel_cnt), 32'(t + 1));
         end
      end
      repeat (300) @(posedge clk);
      chk({lock_close_timeout_fault, cam_relay_out, irq}, 3'b100);
      chk(32'(cancel_cnt), 32'h3);
      rd(ADDR_STATUS, 33'h09880, 33'h10000F8A0);
      apb(1'b1, ADDR_INT_MASK, 32'h1);
      wait_bit(IRQ, 1'b1, 5, n);
      rd(ADDR_INT_STAT, 33'h1, 33'h100000001);
      wait_bit(IRQ, 1'b0, 5, n);
      apb(1'b1, ADDR_CTRL, 32'h27);
      wait_bit(LIT, 1'b0, 10, n);
      zone_req <= 1'b1;
      door_req <= 1'b0;
      wait_bit(FLT, 1'b0, 20, n);
      wait_bit(LIT, 1'b1, 20, n);
      stop_test();
   end
endmodule : manual_door_cam_interlock_bench

//--- dv/mdc_door_model.sv
`timescale 1ns/1ns
module mdc_door_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       cam_relay_out,
   input  wire logic       door_req,
   input  wire logic       jam_aux,
   input  wire logic       shade,
   input  wire logic       level_req,
   input  wire logic       zone_req,
   input  wire logic [7:0] aux_dly,
   output logic            hall_primary_lock_in,
   output logic            series_lock_in,
   output logic            curtain_clear_in,
   output logic            leveling_zone_in,
   output logic            unlock_zone_in
);
   logic [7:0] cam_cnt_r;
   logic       door_r;
   logic       aux_r;

   ////////////////////////////////////////////////////////////////////////////////////
   // slow cam retraction closes aux late; extension opens it at once, a jam never closes it
   always_ff @(posedge clk) begin
      if (rst || !cam_relay_out) begin
         cam_cnt_r <= 8'h00;
         aux_r     <= 1'b0;
      end else begin
         cam_cnt_r <= (cam_cnt_r == 8'hFF) ? cam_cnt_r : cam_cnt_r + 8'h01;
         aux_r     <= (cam_cnt_r >= aux_dly) && !jam_aux;
      end
   end

   // the door opens only when the extended cam pushes the lock inside the zone
   always_ff @(posedge clk) begin
      if (rst) begin
         door_r <= 1'b0;
      end else if (door_req) begin
         door_r <= 1'b1;
      end else if (zone_req && !cam_relay_out) begin
         door_r <= 1'b0;
      end
   end

   // contact levels seen by the block
   assign hall_primary_lock_in = door_r;
   assign series_lock_in       = door_r && aux_r;
   assign curtain_clear_in     = !shade;
   assign leveling_zone_in     = level_req;
   assign unlock_zone_in       = zone_req;
endmodule : mdc_door_model

//--- hw/mdc_interlock.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
module mdc_interlock
   import mdc_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pins from the shaft and car
   input  wire logic        hall_primary_lock_in,
   input  wire logic        series_lock_in,
   input  wire logic        curtain_clear_in,
   input  wire logic        leveling_zone_in,
   input  wire logic        unlock_zone_in,
   // from controller logic on this clock
   input  wire logic        run_dir_req,
   input  wire logic        car_running,
   // outputs
   output logic             cam_relay_out,
   output logic             car_top_close_out,
   output logic             alt_cam_out_a,
   output logic             alt_cam_out_b,
   output logic             brake_release_ok,
   output logic             run_permit,
   output logic             emergency_stop,
   output logic             rescue_run,
   output logic             cancel_calls,
   output logic             lock_close_timeout_fault,
   output logic             curtain_run_fault,
   output logic             cabin_light_on,
   output logic             irq
);

   initial begin
      if (TICK_CYC < 1 || TICK_CYC >= (1 << 23)) $error("TICK_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: change accepted when stages two and three agree
   localparam int unsigned NPIN = 5;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_r;
   logic [NPIN-1:0] s2_r;
   logic [NPIN-1:0] s3_r;
   logic [NPIN-1:0] pin_f_r;
   logic            hall_f;
   logic            series_f;
   logic            curtain_f;
   logic            level_f;
   logic            unlock_f;

   assign pin_raw = {unlock_zone_in, leveling_zone_in, curtain_clear_in,
                     series_lock_in, hall_primary_lock_in};

   genvar gp;
   generate
      for (gp = 0; gp < NPIN; gp++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               s1_r[gp]    <= 1'b0;
               s2_r[gp]    <= 1'b0;
               s3_r[gp]    <= 1'b0;
               pin_f_r[gp] <= 1'b0;
            end else begin
               s1_r[gp] <= pin_raw[gp];
               s2_r[gp] <= s1_r[gp];
               s3_r[gp] <= s2_r[gp];
               if (s2_r[gp] == s3_r[gp]) pin_f_r[gp] <= s3_r[gp];
            end
         end
      end
   endgenerate

   // low on the primary contact means hall door open
   assign hall_f    = pin_f_r[0];
   assign series_f  = pin_f_r[1];
   assign curtain_f = pin_f_r[2];
   assign level_f   = pin_f_r[3];
   assign unlock_f  = pin_f_r[4];

   ////////////////////////////////////////////////////////////////////////////////////
   // prescaled tick
   logic [22:0] pre_r;
   logic        tick_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_r  <= 23'h000000;
         tick_r <= 1'b0;
      end else if (pre_r == 23'(TICK_CYC - 1)) begin
         pre_r  <= 23'h000000;
         tick_r <= 1'b1;
      end else begin
         pre_r  <= pre_r + 23'h000001;
         tick_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // apb registers
   logic [4:0]        ctrl_r;
   logic [7:0]        hold_r;
   logic [7:0]        sel_a_r;
   logic [7:0]        sel_b_r;
   logic [INT_W-1:0]  int_stat_r;
   logic [INT_W-1:0]  int_mask_r;
   logic [INT_W-1:0]  int_set;
   logic              acc;
   logic              wr;
   logic              rd_stat;
   logic              light_off_wr;
   logic [31:0]       rd_nxt;
   logic              mapped;
   mdc_state_t        st_r;
   mdc_state_t        st_nxt;
   logic [1:0]        retry_r;

   // one wait state: pready rises in the second access cycle
   assign acc          = psel && penable && pready;
   assign wr           = acc && pwrite;
   assign rd_stat      = acc && !pwrite && paddr == ADDR_INT_STAT;
   assign light_off_wr = wr && paddr == ADDR_CTRL && pwdata[CTRL_LIGHT_OFF];
   assign mapped       = paddr == ADDR_CTRL || paddr == ADDR_CFG || paddr == ADDR_STATUS
                         || paddr == ADDR_INT_STAT || paddr == ADDR_INT_MASK;

   // read mux
   always_comb begin
      rd_nxt = 32'h00000000;
      case (paddr)
         ADDR_CTRL:     rd_nxt = {27'h0000000, ctrl_r};
         ADDR_CFG:      rd_nxt = {8'h00, sel_b_r, sel_a_r, hold_r};
         ADDR_STATUS:   rd_nxt = {16'h0000, 3'(st_r), retry_r, hall_f, series_f, curtain_f,
                                  lock_close_timeout_fault, curtain_run_fault, cam_relay_out,
                                  run_permit, cabin_light_on, irq, emergency_stop, rescue_run};
         ADDR_INT_STAT: rd_nxt = {28'h0000000, int_stat_r};
         ADDR_INT_MASK: rd_nxt = {28'h0000000, int_mask_r};
         default:       rd_nxt = 32'h00000000;
      endcase
   end

   // bus handshake and read data
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready && !pwrite) prdata <= rd_nxt;
      end
   end

   // writable registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r     <= CTRL_RESET;
         hold_r     <= HOLD_RESET;
         sel_a_r    <= SEL_RESET;
         sel_b_r    <= SEL_RESET;
         int_mask_r <= 4'h0;
      end else if (wr) begin
         if (paddr == ADDR_CTRL) ctrl_r <= pwdata[4:0];
         if (paddr == ADDR_CFG) begin
            hold_r  <= pwdata[CFG_HOLD_LSB +: 8];
            sel_a_r <= pwdata[CFG_SEL_A_LSB +: 8];
            sel_b_r <= pwdata[CFG_SEL_B_LSB +: 8];
         end
         if (paddr == ADDR_INT_MASK) int_mask_r <= pwdata[INT_W-1:0];
      end
   end

   // sticky status, cleared by read; a new event wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         int_stat_r <= 4'h0;
         irq        <= 1'b0;
      end else begin
         int_stat_r <= (rd_stat ? 4'h0 : int_stat_r) | int_set;
         irq        <= |(((rd_stat ? 4'h0 : int_stat_r) | int_set) & int_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // sequencer
   logic [11:0] timer_r;
   logic [11:0] hold_lim;
   logic        cfg_ok;
   logic        lock_to;
   logic        cam_nxt;

   assign cfg_ok  = ctrl_r[CTRL_SEP_LOCK] && ctrl_r[CTRL_SPARE] && ctrl_r[CTRL_MANUAL]
                    && !ctrl_r[CTRL_ADVANCE] && !ctrl_r[CTRL_RELEVEL];
   assign hold_lim = (hold_r < 8'(MIN_HOLD_S) ? 12'(MIN_HOLD_S) : 12'(hold_r))
                     * 12'(TICKS_PER_S);
   assign lock_to  = timer_r >= LOCK_TICKS;

   // next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         MDC_IDLE:
            if (hall_f && run_dir_req && curtain_f && cfg_ok) st_nxt = MDC_CAM_ON;
         MDC_CAM_ON:
            if (series_f) st_nxt = MDC_LOCKED;
            else if (!curtain_f || !hall_f) st_nxt = MDC_IDLE;
            else if (lock_to && retry_r == MAX_RETRIES - 2'h1) st_nxt = MDC_FAULT_LATCH;
            else if (lock_to) st_nxt = MDC_FAULT_WAIT;
         MDC_FAULT_WAIT:
            if (series_f || timer_r >= RETRY_TICKS) st_nxt = MDC_IDLE;
         MDC_FAULT_LATCH:
            if (!hall_f || series_f) st_nxt = MDC_IDLE;
         MDC_LOCKED:
            if (car_running && !curtain_f) st_nxt = MDC_CUR_STOP;
            else if (!series_f) st_nxt = MDC_IDLE;
            else if (car_running) st_nxt = MDC_LOCKED;
            else if (!run_dir_req) st_nxt = MDC_HOLD;
         MDC_CUR_STOP:
            if (curtain_f) st_nxt = MDC_RESCUE;
         MDC_RESCUE:
            if (!curtain_f) st_nxt = MDC_CUR_STOP;
            else if (level_f) st_nxt = MDC_HOLD;
         MDC_HOLD:
            if (!hall_f || timer_r >= hold_lim) st_nxt = MDC_IDLE;
         default:
            st_nxt = MDC_IDLE;
      endcase
   end

   // state, timer and retry count
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r    <= MDC_IDLE;
         timer_r <= 12'h000;
         retry_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         if (st_nxt != st_r) timer_r <= 12'h000;
         else if (tick_r && timer_r != 12'hFFF) timer_r <= timer_r + 12'h001;
         if (st_r == MDC_CAM_ON && series_f) retry_r <= 2'h0;
         else if (st_r == MDC_FAULT_LATCH && st_nxt == MDC_IDLE) retry_r <= 2'h0;
         else if (st_r == MDC_CAM_ON && lock_to) retry_r <= retry_r + 2'h1;
      end
   end

   // faults and call cancel
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_close_timeout_fault <= 1'b0;
         curtain_run_fault        <= 1'b0;
         cancel_calls             <= 1'b0;
      end else begin
         cancel_calls <= st_r == MDC_CAM_ON && !series_f && curtain_f && hall_f && lock_to;
         if (st_r == MDC_CAM_ON && !series_f && curtain_f && hall_f && lock_to)
            lock_close_timeout_fault <= 1'b1;
         else if (series_f || st_nxt == MDC_IDLE && st_r != MDC_CAM_ON)
            lock_close_timeout_fault <= 1'b0;
         if (st_nxt == MDC_CUR_STOP) curtain_run_fault <= 1'b1;
         else if (st_r == MDC_RESCUE && st_nxt == MDC_HOLD) curtain_run_fault <= 1'b0;
      end
   end

   assign int_set = {st_r == MDC_RESCUE && st_nxt == MDC_HOLD,
                     st_r == MDC_CAM_ON && st_nxt == MDC_LOCKED,
                     st_r == MDC_LOCKED && st_nxt == MDC_CUR_STOP,
                     cancel_calls};

   // in hold the cam stays retracted while away from the unlock zone
   assign cam_nxt = st_nxt == MDC_CAM_ON || st_nxt == MDC_LOCKED || st_nxt == MDC_RESCUE
                    || st_nxt == MDC_HOLD && !unlock_f;

   // drive outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         cam_relay_out     <= 1'b0;
         car_top_close_out <= 1'b0;
         brake_release_ok  <= 1'b0;
         run_permit        <= 1'b0;
         emergency_stop    <= 1'b0;
         rescue_run        <= 1'b0;
      end else begin
         cam_relay_out     <= cam_nxt;
         car_top_close_out <= cam_nxt;
         brake_release_ok  <= (st_nxt == MDC_LOCKED || st_nxt == MDC_RESCUE) && series_f;
         run_permit        <= (st_nxt == MDC_LOCKED || st_nxt == MDC_RESCUE) && series_f;
         emergency_stop    <= st_nxt == MDC_CUR_STOP;
         rescue_run        <= st_nxt == MDC_RESCUE;
      end
   end

   // alternate outputs follow their function select
   logic [7:0] sel_v [2];
   logic [1:0] alt_r;
   assign sel_v[0] = sel_a_r;
   assign sel_v[1] = sel_b_r;
   genvar ga;
   generate
      for (ga = 0; ga < 2; ga++) begin : g_alt
         always_ff @(posedge clk) begin
            if (rst) alt_r[ga] <= 1'b0;
            else if (sel_v[ga] == SEL_CAM) alt_r[ga] <= cam_nxt;
            else if (sel_v[ga] == SEL_CAM_INV) alt_r[ga] <= !cam_nxt;
            else alt_r[ga] <= 1'b0;
         end
      end
   endgenerate
   assign alt_cam_out_a = alt_r[0];
   assign alt_cam_out_b = alt_r[1];

   // cabin light: off on request only with hall locked, back on when opened
   always_ff @(posedge clk) begin
      if (rst) cabin_light_on <= 1'b1;
      else if (!hall_f) cabin_light_on <= 1'b1;
      else if (light_off_wr) cabin_light_on <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_close_mirror: assert property (car_top_close_out == cam_relay_out)
      else $error("car top close differs from cam relay");
   chk_cam_needs_lock: assert property ($rose(cam_relay_out) && !$past(st_r == MDC_HOLD)
      |-> $past(hall_f && curtain_f && cfg_ok))
      else $error("cam asserted without hall lock and clear curtain");
   chk_permit_series: assert property ($rose(run_permit) |-> $past(series_f))
      else $error("run permitted without series lock");
   chk_timeout_raise: assert property ($rose(lock_close_timeout_fault)
      |-> $past(st_r == MDC_CAM_ON && timer_r >= LOCK_TICKS) && cancel_calls)
      else $error("timeout fault without 10 s in cam state");
   chk_fault_cam_off: assert property (st_r == MDC_FAULT_WAIT |-> ##1 !cam_relay_out)
      else $error("cam still out during fault wait");
   chk_latch_retry: assert property (st_r == MDC_FAULT_LATCH |-> retry_r == 2'h3)
      else $error("latched fault before three failures");
   chk_curtain_stop: assert property (st_r == MDC_LOCKED && car_running && !curtain_f
      |-> ##1 st_r == MDC_CUR_STOP ##0 emergency_stop && curtain_run_fault)
      else $error("shaded curtain did not stop the car");
   chk_alt_cam: assert property ($past(sel_a_r) == SEL_CAM && sel_a_r == SEL_CAM
      |-> alt_cam_out_a == cam_relay_out)
      else $error("alternate output does not follow cam");
   chk_alt_inv: assert property ($past(sel_b_r) == SEL_CAM_INV && sel_b_r == SEL_CAM_INV
      |-> alt_cam_out_b != cam_relay_out)
      else $error("alternate output is not inverted cam");
   chk_light_back: assert property (!hall_f |-> ##1 cabin_light_on)
      else $error("cabin light not restored on door open");

   cov_timeout: cover property (st_r == MDC_CAM_ON ##1 st_r == MDC_FAULT_WAIT);
   cov_latch: cover property (st_r == MDC_FAULT_LATCH ##1 st_r == MDC_IDLE);
   cov_rescue: cover property (st_r == MDC_RESCUE ##1 st_r == MDC_HOLD);

endmodule : mdc_interlock

//--- hw/mdc_pkg.sv
// Overview of operation
// - hall primary lock inactive open, active closed
// - cam needs hall lock, direction, clear curtain
// - brake and run only after series lock
// - no lock in 10 s: fault, cancel calls
// - fault clears when lock circuit closes
// - on fault drop cam, retry after 5 s
// - three failures latch until reopen or lock
// - light off allowed when hall locked
// - shaded curtain before run blocks cam, close
// - shaded curtain while running: stop, fault
// - curtain clears: rescue run to leveling
// - wait hold time after stop, minimum 10 s
// - car-top close mirrors cam relay output
// - select code 5 copies cam logic
// - select code 23 gives inverted cam logic
// - manual door needs the five config settings
// - in hold, cam extends only inside unlock zone
package mdc_pkg;

   ////////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned TICK_NS        = 100_000_000;
   localparam int unsigned TICK_CYC_DEF   = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned TICKS_PER_S    = 10;
   localparam int unsigned LOCK_TIMEOUT_S = 10;
   localparam int unsigned RETRY_WAIT_S   = 5;
   localparam int unsigned MIN_HOLD_S     = 10;
   localparam logic [11:0] LOCK_TICKS     = 12'(LOCK_TIMEOUT_S * TICKS_PER_S);
   localparam logic [11:0] RETRY_TICKS    = 12'(RETRY_WAIT_S * TICKS_PER_S);
   localparam logic [1:0]  MAX_RETRIES    = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses)
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_CFG       = 12'h004;
   localparam logic [11:0] ADDR_STATUS    = 12'h008;
   localparam logic [11:0] ADDR_INT_STAT  = 12'h00C;
   localparam logic [11:0] ADDR_INT_MASK  = 12'h010;

   // control bit positions
   localparam int unsigned CTRL_SEP_LOCK  = 0;
   localparam int unsigned CTRL_SPARE     = 1;
   localparam int unsigned CTRL_MANUAL    = 2;
   localparam int unsigned CTRL_ADVANCE   = 3;
   localparam int unsigned CTRL_RELEVEL   = 4;
   localparam int unsigned CTRL_LIGHT_OFF = 5;
   localparam logic [4:0]  CTRL_RESET     = 5'h00;

   // configuration fields and reset values
   localparam int unsigned CFG_HOLD_LSB   = 0;
   localparam int unsigned CFG_SEL_A_LSB  = 8;
   localparam int unsigned CFG_SEL_B_LSB  = 16;
   localparam logic [7:0]  HOLD_RESET     = 8'h0A;
   localparam logic [7:0]  SEL_RESET      = 8'h00;
   localparam logic [7:0]  SEL_CAM        = 8'h05;
   localparam logic [7:0]  SEL_CAM_INV    = 8'h17;

   // interrupt status bits
   localparam int unsigned INT_TIMEOUT    = 0;
   localparam int unsigned INT_CURTAIN    = 1;
   localparam int unsigned INT_LOCKED     = 2;
   localparam int unsigned INT_RESCUED    = 3;
   localparam int unsigned INT_W          = 4;

   // sequencer states
   typedef enum logic [2:0] {
      MDC_IDLE, MDC_CAM_ON, MDC_LOCKED, MDC_FAULT_WAIT,
      MDC_FAULT_LATCH, MDC_CUR_STOP, MDC_RESCUE, MDC_HOLD
   } mdc_state_t;

endpackage : mdc_pkg
